// ### design/nrc_defines.svh
// Offsets, field positions and reset values of the run-control block
`ifndef NRC_DEFINES_SVH
`define NRC_DEFINES_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define NRC_ADR_CTRL     8'h00
`define NRC_ADR_PTR_LO   8'h04
`define NRC_ADR_PTR_HI   8'h08
`define NRC_ADR_CFG      8'h0C
`define NRC_ADR_PTR_LOA  8'h40
`define NRC_ADR_PTR_HIA  8'h44
// ****************************************
// Control and status fields
// ****************************************
`define NRC_CTL_INIT     0
`define NRC_CTL_RUN      1
`define NRC_CTL_STOP     2
`define NRC_CTL_DEMAND   3
`define NRC_CTL_TRANSMIT_ENABLED_FLAG     4
`define NRC_CTL_RXON     5
`define NRC_CTL_IDONE    6
// ****************************************
// Configuration fields and reset value
// ****************************************
`define NRC_CFG_WIDE     0
`define NRC_CFG_NOPOLL   1
`define NRC_CFG_TXDIS    2
`define NRC_CFG_RXDIS    3
`define NRC_CFG_RESET    4'h0
`define NRC_ZERO32       32'h0000_0000
`endif

// ### design/nrc_pkg.sv
// Types and shared helper functions of the run-control block
package nrc_pkg;
  // Run-control states, one-hot
  typedef enum logic [3:0] {
    NRC_ST_STOP = 4'b0001,
    NRC_ST_INIT = 4'b0010,
    NRC_ST_IDLE = 4'b0100,
    NRC_ST_RUN  = 4'b1000
  } nrc_state_t;

  // Byte-lane merge of a 16-bit field under two byte enables
  function automatic logic [15:0] nrc_merge16(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  sel);
    nrc_merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
                   sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // Narrow structures carry 24 address bits; the pointer byte fills the top
  function automatic logic [31:0] nrc_ext_addr(input logic [31:0] addr,
                                               input logic [7:0]  upper,
                                               input logic        wide);
    nrc_ext_addr = wide ? addr : {upper, addr[23:0]};
  endfunction
endpackage

// ### design/nrc_ptr_regs.sv
// Storage of the setup-block pointer, shared by the main and alias locations
`timescale 1ns/1ps
`default_nettype none
module nrc_ptr_regs
  import nrc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        wr_lo_i,
  input  wire logic        wr_hi_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [15:0] lo_o,
  output logic      [15:0] hi_o
);
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  logic [15:0] lo_next;
  logic [15:0] hi_next;

  // One storage word per pointer half, so both locations always agree
  assign lo_next = nrc_merge16(lo_reg, dat_i[15:0], sel_i[1:0]);
  assign hi_next = nrc_merge16(hi_reg, dat_i[15:0], sel_i[1:0]);
  assign lo_o    = lo_reg;
  assign hi_o    = hi_reg;

  // No reset on purpose: contents survive every reset and stop
  always_ff @(posedge clk_i)
  begin
    if (wr_lo_i)
      lo_reg <= lo_next;
    if (wr_hi_i)
      hi_reg <= hi_next;
  end
endmodule
`default_nettype wire

// ### design/nrc_addr_ext.sv
// Registered upper-byte extension of one bus-master address
`timescale 1ns/1ps
`default_nettype none
module nrc_addr_ext
  import nrc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wide_i,
  input  wire logic [7:0]  upper_i,
  input  wire logic [31:0] addr_i,
  output logic      [31:0] addr_o
);
  logic [31:0] addr_reg;
  logic [31:0] addr_next;

  // Overwrites the stored top byte for narrow structures
  assign addr_next = nrc_ext_addr(addr_i, upper_i, wide_i);
  assign addr_o    = addr_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      addr_reg <= 32'h0000_0000;
    else
      addr_reg <= addr_next;
  end
endmodule
`default_nettype wire

// ### design/nrc_top.sv
// Run control, transmit demand and setup-block pointer with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "nrc_defines.svh"
module nrc_top
  import nrc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        soft_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             dma_enable_o,
  output logic             run_active_o,
  output logic             tx_enabled_o,
  output logic             rx_enabled_o,
  output logic             auto_poll_en_o,
  output logic             tx_ring_poll_o,
  input  wire logic        tx_desc_fetched_i,
  output logic             init_fetch_o,
  output logic      [31:0] init_addr_o,
  input  wire logic        init_done_i,
  output logic             wide_select_o,
  input  wire logic [31:0] desc_base_i,
  output logic      [31:0] desc_base_o,
  input  wire logic [31:0] buf_addr_i,
  output logic      [31:0] buf_addr_o
);
  // ****************************************
  // Declarations
  // ****************************************
  nrc_state_t  st_reg;
  nrc_state_t  st_next;
  logic        stop_reg;
  logic        stop_next;
  logic        run_reg;
  logic        run_next;
  logic        init_reg;
  logic        init_next;
  logic        dmd_reg;
  logic        dmd_next;
  logic        transmit_enabled_flag_reg;
  logic        transmit_enabled_flag_next;
  logic        rxon_reg;
  logic        rxon_next;
  logic        idone_reg;
  logic        idone_next;
  logic        poll_reg;
  logic        dma_reg;
  logic        fetch_reg;
  logic        run_act_reg;
  logic        apoll_reg;
  logic [31:0] iaddr_reg;
  logic [31:0] iaddr_next;
  logic [3:0]  cfg_reg;
  logic [3:0]  cfg_next;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] dat_reg;
  logic        any_rst;
  logic        acc;
  logic        wr;
  logic        hit_ctrl;
  logic        hit_cfg;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_any;
  logic        wr_ctrl;
  logic        w_stop;
  logic        w_run;
  logic        w_init;
  logic        w_dmd;
  logic        wr_lo;
  logic        wr_hi;
  logic [15:0] ptr_lo;
  logic [15:0] ptr_hi;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_lo;
  logic [31:0] rd_hi;
  logic [31:0] rd_cfg;
  logic [31:0] rd_mux;
  logic        wide;
  logic        txdis;
  logic        rxdis;
  logic        nopoll;

  // ****************************************
  // Bus decode
  // ****************************************
  // Hardware and software reset act alike on control state
  assign any_rst  = rst_i | soft_rst_i;
  // A request is taken once; the ack cycle blocks a second take
  assign acc      = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  assign wr       = acc & wb_we_i;
  assign hit_ctrl = (wb_adr_i == `NRC_ADR_CTRL);
  assign hit_cfg  = (wb_adr_i == `NRC_ADR_CFG);
  assign hit_lo   = (wb_adr_i == `NRC_ADR_PTR_LO)
                  | (wb_adr_i == `NRC_ADR_PTR_LOA);
  assign hit_hi   = (wb_adr_i == `NRC_ADR_PTR_HI)
                  | (wb_adr_i == `NRC_ADR_PTR_HIA);
  assign hit_any  = hit_ctrl | hit_cfg | hit_lo | hit_hi;

  // ****************************************
  // Control write strobes
  // ****************************************
  // A stop in the same write masks start, init and demand
  assign wr_ctrl = wr & hit_ctrl & wb_sel_i[0];
  assign w_stop  = wr_ctrl & wb_dat_i[`NRC_CTL_STOP];
  assign w_run   = wr_ctrl & wb_dat_i[`NRC_CTL_RUN] & ~w_stop;
  assign w_init  = wr_ctrl & wb_dat_i[`NRC_CTL_INIT] & ~w_stop;
  assign w_dmd   = wr_ctrl & wb_dat_i[`NRC_CTL_DEMAND] & ~w_stop;

  // Pointer writes are dropped unless stopped
  assign wr_lo   = wr & hit_lo & stop_reg;
  assign wr_hi   = wr & hit_hi & stop_reg;

  // Configuration fields
  assign wide    = cfg_reg[`NRC_CFG_WIDE];
  assign nopoll  = cfg_next[`NRC_CFG_NOPOLL];
  assign txdis   = cfg_reg[`NRC_CFG_TXDIS];
  assign rxdis   = cfg_reg[`NRC_CFG_RXDIS];
  assign cfg_next = (wr & hit_cfg & wb_sel_i[0]) ? wb_dat_i[3:0] : cfg_reg;

  // ****************************************
  // Pointer storage and address extension
  // ****************************************
  nrc_ptr_regs u_ptr (
    .clk_i   (clk_i),
    .wr_lo_i (wr_lo),
    .wr_hi_i (wr_hi),
    .sel_i   (wb_sel_i),
    .dat_i   (wb_dat_i),
    .lo_o    (ptr_lo),
    .hi_o    (ptr_hi)
  );

  // Descriptor bases pick up the high pointer byte when narrow
  nrc_addr_ext u_desc_ext (
    .clk_i   (clk_i),
    .rst_i   (any_rst),
    .wide_i  (wide),
    .upper_i (ptr_hi[15:8]),
    .addr_i  (desc_base_i),
    .addr_o  (desc_base_o)
  );

  // Buffer start addresses are extended the same way
  nrc_addr_ext u_buf_ext (
    .clk_i   (clk_i),
    .rst_i   (any_rst),
    .wide_i  (wide),
    .upper_i (ptr_hi[15:8]),
    .addr_i  (buf_addr_i),
    .addr_o  (buf_addr_o)
  );

  // ****************************************
  // Run-control flags
  // ****************************************
  // Setting start or init releases stop; stop clears start and init
  assign stop_next = w_stop ? 1'b1 : ((w_run | w_init) ? 1'b0 : stop_reg);
  assign run_next  = w_stop ? 1'b0 : (run_reg | w_run);
  // Init stays set after the sequence completes
  assign init_next = w_stop ? 1'b0 : (init_reg | w_init);

  // Setup-block address; narrow mode gives the same 32 bits by prepending
  assign iaddr_next = w_init ? {ptr_hi, ptr_lo} : iaddr_reg;

  // ****************************************
  // Sequencer
  // ****************************************
  // Init written with start runs before start takes effect; start alone from stop goes straight to run
  always_comb
  begin
    st_next = st_reg;
    if (w_stop)
      st_next = NRC_ST_STOP;
    else if (w_init)
      st_next = NRC_ST_INIT;
    else
      case (st_reg)
        NRC_ST_STOP:
          if (w_run)
            st_next = NRC_ST_RUN;
        NRC_ST_INIT:
          if (init_done_i)
            st_next = (run_reg | w_run) ? NRC_ST_RUN : NRC_ST_IDLE;
        NRC_ST_IDLE:
          if (w_run)
            st_next = NRC_ST_RUN;
        NRC_ST_RUN:
          st_next = NRC_ST_RUN;
        default:
          st_next = NRC_ST_STOP;
      endcase
  end

  // ****************************************
  // Transmit demand and enables
  // ****************************************
  // Enables follow the run state so they stay low while init runs
  assign transmit_enabled_flag_next = (st_next == NRC_ST_RUN) & ~txdis;
  assign rxon_next = (st_next == NRC_ST_RUN) & ~rxdis;
  assign idone_next = w_stop ? 1'b0
                    : (w_init ? 1'b0
                    : (idone_reg | ((st_reg == NRC_ST_INIT) & init_done_i)));

  // A new demand wins over a fetch in the same cycle so none is lost;
  // with transmit off the demand falls back at once
  always_comb
  begin
    if (w_stop)
      dmd_next = 1'b0;
    else if (w_dmd)
      dmd_next = transmit_enabled_flag_reg;
    else if (tx_desc_fetched_i)
      dmd_next = 1'b0;
    else
      dmd_next = dmd_reg & transmit_enabled_flag_next;
  end

  // ****************************************
  // Register read mux
  // ****************************************
  assign rd_ctrl = {25'h000_0000, idone_reg, rxon_reg, transmit_enabled_flag_reg,
                    dmd_reg, stop_reg, run_reg, init_reg};
  // Reserved upper halves read zero; pointers read zero unless stopped
  assign rd_lo   = stop_reg ? {16'h0000, ptr_lo} : `NRC_ZERO32;
  assign rd_hi   = stop_reg ? {16'h0000, ptr_hi} : `NRC_ZERO32;
  assign rd_cfg  = {28'h000_0000, cfg_reg};
  assign rd_mux  = hit_ctrl ? rd_ctrl
                 : hit_cfg  ? rd_cfg
                 : hit_lo   ? rd_lo
                 : hit_hi   ? rd_hi
                 : `NRC_ZERO32;

  // ****************************************
  // Control registers
  // ****************************************
  // Both resets put the block in stop; pointers are untouched
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      st_reg    <= NRC_ST_STOP;
      stop_reg  <= 1'b1;
      run_reg   <= 1'b0;
      init_reg  <= 1'b0;
      dmd_reg   <= 1'b0;
      transmit_enabled_flag_reg  <= 1'b0;
      rxon_reg  <= 1'b0;
      idone_reg <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      stop_reg  <= stop_next;
      run_reg   <= run_next;
      init_reg  <= init_next;
      dmd_reg   <= dmd_next;
      transmit_enabled_flag_reg  <= transmit_enabled_flag_next;
      rxon_reg  <= rxon_next;
      idone_reg <= idone_next;
    end
  end

  // Configuration survives software reset, cleared by hardware reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_reg <= `NRC_CFG_RESET;
    else
      cfg_reg <= cfg_next;
  end

  // ****************************************
  // Engine outputs
  // ****************************************
  // Registered so the engines see one consistent snapshot per cycle
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      dma_reg   <= 1'b0;
      poll_reg  <= 1'b0;
      fetch_reg <= 1'b0;
      iaddr_reg <= `NRC_ZERO32;
      run_act_reg <= 1'b0;
      apoll_reg <= 1'b0;
    end
    else
    begin
      dma_reg   <= ~stop_next;
      poll_reg  <= dmd_next & transmit_enabled_flag_next;
      fetch_reg <= (st_next == NRC_ST_INIT);
      iaddr_reg <= iaddr_next;
      run_act_reg <= transmit_enabled_flag_next | rxon_next;
      apoll_reg <= transmit_enabled_flag_next & ~nopoll;
    end
  end

  // ****************************************
  // Wishbone answer
  // ****************************************
  // Single-cycle answer; unmapped addresses get err instead of ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= `NRC_ZERO32;
    end
    else
    begin
      ack_reg <= acc & hit_any;
      err_reg <= acc & ~hit_any;
      dat_reg <= (acc & ~wb_we_i) ? rd_mux : `NRC_ZERO32;
    end
  end

  // ****************************************
  // Output assignment
  // ****************************************
  assign wb_dat_o       = dat_reg;
  assign wb_ack_o       = ack_reg;
  assign wb_err_o       = err_reg;
  assign dma_enable_o   = dma_reg;
  assign run_active_o   = run_act_reg;
  assign tx_enabled_o   = transmit_enabled_flag_reg;
  assign rx_enabled_o   = rxon_reg;
  // Polling is on while transmit is enabled, unless software turned it off
  assign auto_poll_en_o = apoll_reg;
  assign tx_ring_poll_o = poll_reg;
  assign init_fetch_o   = fetch_reg;
  assign init_addr_o    = iaddr_reg;
  assign wide_select_o  = wide;
endmodule
`default_nettype wire

// ### test/nrc_properties.sv
// Concurrent checks on the ports of the run-control block
`timescale 1ns/1ps
`default_nettype none
module nrc_properties
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        soft_rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        dma_enable_o,
  input wire logic        tx_enabled_o,
  input wire logic        tx_ring_poll_o,
  input wire logic        tx_desc_fetched_i,
  input wire logic        init_fetch_o,
  input wire logic        wide_select_o,
  input wire logic [31:0] desc_base_i,
  input wire logic [31:0] desc_base_o,
  input wire logic [31:0] buf_addr_i,
  input wire logic [31:0] buf_addr_o
);
  // ****************************************
  // Request decode and checks
  // ****************************************
  // A request is new only while no answer is showing
  wire req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire ctl_wr = req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
  wire mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h40, 8'h44};
  logic rst_q;
  // Reset as seen one edge back, for the checks that compare against past inputs
  always_ff @(posedge clk_i)
    rst_q <= rst_i || soft_rst_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || soft_rst_i);

  bus_answer_a: assert property (req |=> wb_ack_o != wb_err_o)
    else $error("bus request not answered in one cycle");
  err_map_a: assert property (req && !mapped |=> wb_err_o && wb_dat_o == 32'h0)
    else $error("unmapped access not refused");
  stop_wins_a: assert property (ctl_wr && wb_dat_i[2] |-> ##2 !dma_enable_o
    && !tx_enabled_o && !init_fetch_o && !tx_ring_poll_o) else $error("stop did not halt");
  demand_poll_a: assert property (ctl_wr && wb_dat_i[3:0] == 4'h8 && tx_enabled_o
    |=> tx_ring_poll_o) else $error("demand did not start a ring read");
  demand_drop_a: assert property (ctl_wr && wb_dat_i[3:0] == 4'h8 && !tx_enabled_o
    |=> !tx_ring_poll_o) else $error("demand kept with transmit off");
  fetch_clear_a: assert property (tx_desc_fetched_i && !ctl_wr |-> ##[1:2] !tx_ring_poll_o)
    else $error("fetch did not clear demand");
  poll_gate_a: assert property (tx_ring_poll_o |-> tx_enabled_o && dma_enable_o)
    else $error("ring read while transmit off");
  init_first_a: assert property (init_fetch_o |-> !tx_enabled_o)
    else $error("transmit on during setup fetch");
  init_go_a: assert property (ctl_wr && wb_dat_i[0] && !wb_dat_i[2] |-> ##[1:2] init_fetch_o)
    else $error("setup fetch did not start");
  wide_pass_a: assert property (wide_select_o && $past(wide_select_o) && !rst_q
    |-> desc_base_o == $past(desc_base_i) && buf_addr_o == $past(buf_addr_i))
    else $error("wide address altered");
  narrow_low_a: assert property (!$past(wide_select_o) && !rst_q
    |-> ((desc_base_o ^ $past(desc_base_i)) & 32'h00FF_FFFF) == 32'h0)
    else $error("narrow address low bits altered");
  cover property (ctl_wr ##1 init_fetch_o);
  cover property (tx_ring_poll_o ##1 !tx_ring_poll_o);
  cover property (req && !mapped);
endmodule
bind nrc_top nrc_properties u_props (.clk_i, .rst_i, .soft_rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
  .dma_enable_o, .tx_enabled_o, .tx_ring_poll_o, .tx_desc_fetched_i, .init_fetch_o,
  .wide_select_o, .desc_base_i, .desc_base_o, .buf_addr_i, .buf_addr_o);
`default_nettype wire

// ### test/nrc_dma_model.sv
// Behavioural DMA engine answering setup-block fetches and ring reads
`timescale 1ns/1ps
`default_nettype none
module nrc_dma_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] lat_i,
  input  wire logic       init_fetch_i,
  input  wire logic       tx_ring_poll_i,
  output var logic        init_done_o = 1'b0,
  output var logic        tx_desc_fetched_o = 1'b0
);
  logic [3:0] icnt_reg = 4'h0;
  logic [3:0] tcnt_reg = 4'h0;
  wire ibusy = init_fetch_i && !init_done_o && !rst_i;
  wire tbusy = tx_ring_poll_i && !tx_desc_fetched_o && !rst_i;
  // Answers come lat_i + 1 cycles late, so slow memory is seen as well as fast
  always @(posedge clk_i)
  begin
    icnt_reg          <= ibusy ? icnt_reg + 4'h1 : 4'h0;
    tcnt_reg          <= tbusy ? tcnt_reg + 4'h1 : 4'h0;
    init_done_o       <= ibusy && icnt_reg == lat_i;
    tx_desc_fetched_o <= tbusy && tcnt_reg == lat_i;
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench of the run-control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        soft_rst_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] desc_base_i = 32'h0;
  logic [31:0] buf_addr_i = 32'h0;
  logic [3:0]  lat = 4'h6;
  logic [31:0] rnd = 32'hD;
  logic [31:0] d, b, wb_dat_o, init_addr_o, desc_base_o, buf_addr_o;
  logic        wb_ack_o, wb_err_o, dma_enable_o, run_active_o, tx_enabled_o;
  logic        rx_enabled_o, auto_poll_en_o, tx_ring_poll_o, init_fetch_o;
  logic        wide_select_o, tx_desc_fetched_i, init_done_i;
  logic [31:0] expq[$];
  int          n_fail = 0;
  int          checks = 0;
  int          i;

  // ****************************************
  // Clock, partner, design and helpers
  // ****************************************
  // Clock of 100 MHz
  always #5 clk_i = ~clk_i;
  nrc_top DUT (.clk_i, .rst_i, .soft_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .dma_enable_o, .run_active_o,
    .tx_enabled_o, .rx_enabled_o, .auto_poll_en_o, .tx_ring_poll_o, .tx_desc_fetched_i,
    .init_fetch_o, .init_addr_o, .init_done_i, .wide_select_o, .desc_base_i, .desc_base_o,
    .buf_addr_i, .buf_addr_o);
  nrc_dma_model u_dma (.clk_i, .rst_i, .lat_i(lat), .init_fetch_i(init_fetch_o),
    .tx_ring_poll_i(tx_ring_poll_o), .init_done_o(init_done_i),
    .tx_desc_fetched_o(tx_desc_fetched_i));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Fresh random addresses each cycle keep the extension path busy
  always @(posedge clk_i)
  begin
    rnd         <= lfsr(rnd);
    desc_base_i <= rnd;
    buf_addr_i  <= ~rnd;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One classic cycle; request held until the edge that samples the answer
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    // No cycle count assumed; only the watchdog ends a stuck wait
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
      @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic await(ref logic s, input logic v);
    for (int n = 0; n < 40 && s !== v; n++)
      @(posedge clk_i);
  endtask
  // Read answers are matched in order against the notes left by the driver
  always @(posedge clk_i)
    if (wb_cyc_i && !wb_we_i && (wb_ack_o === 1'b1 || wb_err_o === 1'b1) && expq.size() > 0)
      check("read data", wb_dat_o, expq.pop_front());
  // A healthy run takes about 130 cycles; 20000 means a hang
  initial
  begin
    #200000;
    n_fail++;
    finish_test();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("dma", dma_enable_o, 1'b0);
    rd(8'h00, 32'h4);
    bus(1'b1, 8'h04, 32'hFFFF_1234);
    rd(8'h04, 32'h1234);
    rd(8'h40, 32'h1234);
    bus(1'b1, 8'h44, 32'hFFFF_AB56);
    rd(8'h08, 32'hAB56);
    bus(1'b1, 8'h40, 32'h5678);
    rd(8'h04, 32'h5678);
    soft_rst_i <= 1'b1;
    @(posedge clk_i) soft_rst_i <= 1'b0;
    rd(8'h04, 32'h5678);
    rd(8'h20, 32'h0);
    $display("test pointers finished");
    // Start and setup together: setup fetch comes first
    bus(1'b1, 8'h00, 32'h3);
    @(posedge clk_i);
    check("fetch", init_fetch_o, 1'b1);
    check("transmit_enabled_flag", tx_enabled_o, 1'b0);
    check("iaddr", init_addr_o, 32'hAB56_5678);
    await(tx_enabled_o, 1'b1);
    check("run", run_active_o, 1'b1);
    check("rxon", rx_enabled_o, 1'b1);
    check("dma", dma_enable_o, 1'b1);
    rd(8'h00, 32'h73);
    bus(1'b1, 8'h04, 32'hFFFF);
    rd(8'h04, 32'h0);
    $display("test init finished");
    // Demand while running, auto polling switched off
    lat <= 4'h2;
    bus(1'b1, 8'h0C, 32'h2);
    check("apoll", auto_poll_en_o, 1'b0);
    bus(1'b1, 8'h00, 32'h8);
    check("poll", tx_ring_poll_o, 1'b1);
    await(tx_ring_poll_o, 1'b0);
    check("poll", tx_ring_poll_o, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h73);
    $display("test demand finished");
    // Upper byte of bus-master addresses in both structure sizes
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 8'h0C, i);
      check("wide", wide_select_o, i);
      @(posedge clk_i) d = desc_base_i;
      b = buf_addr_i;
      @(posedge clk_i);
      check("desc", desc_base_o, i ? d : {8'hAB, d[23:0]});
      check("buf", buf_addr_o, i ? b : {8'hAB, b[23:0]});
    end
    $display("test extension finished");
    // Stop beats start and setup written together
    bus(1'b1, 8'h00, 32'h7);
    check("dma", dma_enable_o, 1'b0);
    check("fetch", init_fetch_o, 1'b0);
    check("transmit_enabled_flag", tx_enabled_o, 1'b0);
    check("rxon", rx_enabled_o, 1'b0);
    rd(8'h00, 32'h4);
    bus(1'b1, 8'h00, 32'h8);
    check("poll", tx_ring_poll_o, 1'b0);
    rd(8'h00, 32'h4);
    // Start with transmit disabled: receive runs, demand falls back
    bus(1'b1, 8'h0C, 32'h4);
    bus(1'b1, 8'h00, 32'hA);
    check("transmit_enabled_flag", tx_enabled_o, 1'b0);
    check("rxon", rx_enabled_o, 1'b1);
    check("poll", tx_ring_poll_o, 1'b0);
    rd(8'h00, 32'h22);
    $display("test stop finished");
    finish_test();
  end
endmodule
`default_nettype wire
